// ===== core/vqe_exit_encoder.sv
// Exit-detail encoder: builds the 64-bit qualification word per exit and serves it over APB.
//
// Functional notes
// - Debug-register move: register index goes into bits 2:0.
// - Debug-register move: bit 4 is 0 for write into, 1 for read out.
// - Debug-register move: general-purpose register operand index in bits 11:8.
// - Debug-register move: bits 3, 7:5 and 63:12 are zero.
// - Port I/O: size in bits 2:0 as 0, 1 or 3 only.
// - Port I/O: bit 3 is 0 for output, 1 for input.
// - Port I/O: bit 4 flags the string form.
// - Port I/O: bit 5 flags the repeat prefix.
// - Port I/O: bit 6 is 0 for port from DX, 1 for immediate.
// - Port I/O: 16-bit port number in bits 31:16.
// - Port I/O: bits 15:7 and 63:32 are zero.
// - Monitor-wait: whole word is 1 when monitoring armed, else 0.
// - Page access, linear: offset within the page in bits 11:0.
// - Page access: type code in bits 15:12 from the six allowed values.
// - Data read or write follows the page-fault write/read bit.
// - Flush and monitor-setup read; stack enter and masked stores write.
// - Vectoring flag EVENT_VEC_VALID, outside the word, set only for access types 3 and 10.
// - Physical page access word is zero; bits 63:16 zero otherwise.
// - Translation violation: bits 0, 1, 2 for read, write, fetch.
`timescale 1ns/100ps

module vqe_exit_encoder (
  // Clock and reset.
  input  wire logic        CORE_CLK,
  input  wire logic        RESET_N,
  // APB slave.
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // Exit event from the core.
  input  wire logic        EXIT_VALID,
  input  wire logic [2:0]  EXIT_REASON,
  // Debug-register move attributes.
  input  wire logic [2:0]  DR_INDEX,
  input  wire logic        DR_READ_OUT,
  input  wire logic [3:0]  GPR_INDEX,
  // Port I/O attributes.
  input  wire logic [1:0]  IO_SIZE,
  input  wire logic        IO_INPUT,
  input  wire logic        IO_STRING,
  input  wire logic        IO_REPEAT,
  input  wire logic        IO_IMMEDIATE,
  input  wire logic [15:0] IO_PORT,
  // Monitor-wait attribute.
  input  wire logic        MON_ARMED,
  // Interrupt-controller page access attributes.
  input  wire logic [2:0]  LIC_KIND,
  input  wire logic [2:0]  LIC_INSTR,
  input  wire logic        LIC_PF_WRITE,
  input  wire logic [11:0] LIC_OFFSET,
  // Second-level translation violation attributes.
  input  wire logic        SLT_READ,
  input  wire logic        SLT_WRITE,
  input  wire logic        SLT_FETCH,
  // Results.
  output logic      [63:0] EXIT_DETAIL,
  output logic             EVENT_VEC_VALID,
  output logic             DETAIL_VALID
);

  typedef struct packed {
    logic [63:0] detail;
    logic        vec;
    logic        valid;
    logic [2:0]  reason;
    logic        enable;
    logic [31:0] prdata;
    logic        pslverr;
  } vqe_state_t;

  vqe_state_t s_r;
  vqe_state_t s_nxt;
  logic [1:0] rst_sync_r;
  logic       rst_n;

  ////////////////////////////////////////////////////////////////////////////////

  // Release of the asynchronous reset is retimed so no flop sees it mid-edge.
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  ////////////////////////////////////////////////////////////////////////////////

  function automatic logic addr_known(input logic [7:0] a);
    addr_known = (a == vqe_pkg::ADDR_DETAIL_LO) || (a == vqe_pkg::ADDR_DETAIL_HI) ||
                 (a == vqe_pkg::ADDR_STATUS) || (a == vqe_pkg::ADDR_CONTROL);
  endfunction

  // Picks the page access type; data reads and writes follow the fault W/R sense.
  function automatic logic [3:0] lic_type(input logic [2:0] kind, input logic [2:0] instr,
                                          input logic pf_wr);
    logic wr;
    wr = pf_wr;
    case (vqe_pkg::vqe_instr_t'(instr))
      vqe_pkg::IC_CACHE_FLUSH, vqe_pkg::IC_MONITOR_SETUP: wr = 1'b0;
      vqe_pkg::IC_STACK_ENTER, vqe_pkg::IC_MASKED_STORE_A,
      vqe_pkg::IC_MASKED_STORE_B: wr = 1'b1;
      default: wr = pf_wr;
    endcase
    case (vqe_pkg::vqe_lic_kind_t'(kind))
      vqe_pkg::LK_LIN_DATA:  lic_type = wr ? vqe_pkg::AT_DATA_WR : vqe_pkg::AT_DATA_RD;
      vqe_pkg::LK_LIN_FETCH: lic_type = vqe_pkg::AT_FETCH;
      vqe_pkg::LK_LIN_EVENT: lic_type = vqe_pkg::AT_LIN_EVT;
      vqe_pkg::LK_GP_EVENT:  lic_type = vqe_pkg::AT_GP_EVT;
      default:               lic_type = vqe_pkg::AT_GP_EXEC;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////////

  logic        take;
  logic [63:0] word;
  logic        vec;
  logic [3:0]  at;
  logic        apb_wr;
  logic        apb_setup;
  logic        clr_req;

  assign take      = EXIT_VALID && s_r.enable;
  assign apb_wr    = PSEL && PENABLE && PWRITE;
  assign apb_setup = PSEL && !PENABLE;
  // A completed write of the clear bit; only used to qualify the assertions below.
  assign clr_req   = apb_wr && (PADDR == vqe_pkg::ADDR_CONTROL) && PWDATA[vqe_pkg::CTRL_CLEAR_BIT];
  assign at        = lic_type(LIC_KIND, LIC_INSTR, LIC_PF_WRITE);

  // Every format starts from an all-zero word, so reserved and undefined bits read zero.
  always_comb begin
    word = 64'h0;
    vec  = 1'b0;
    case (vqe_pkg::vqe_reason_t'(EXIT_REASON))
      vqe_pkg::RSN_DR_MOVE: begin
        word[2:0]                = DR_INDEX;
        word[vqe_pkg::DR_DIR_BIT] = DR_READ_OUT;
        word[11:8]               = GPR_INDEX;
      end
      vqe_pkg::RSN_PORT_IO: begin
        case (IO_SIZE)
          2'h0:    word[2:0] = vqe_pkg::IO_SZ_1;
          2'h1:    word[2:0] = vqe_pkg::IO_SZ_2;
          default: word[2:0] = vqe_pkg::IO_SZ_4;
        endcase
        word[vqe_pkg::IO_IN_BIT]  = IO_INPUT;
        word[vqe_pkg::IO_STR_BIT] = IO_STRING;
        word[vqe_pkg::IO_REP_BIT] = IO_REPEAT;
        word[vqe_pkg::IO_IMM_BIT] = IO_IMMEDIATE;
        word[31:16]               = IO_PORT;
      end
      vqe_pkg::RSN_MON_WAIT: begin
        word[0] = MON_ARMED;
      end
      vqe_pkg::RSN_LIC_PAGE: begin
        // A physical access has no defined word; it is left all zero.
        if (LIC_KIND != vqe_pkg::LK_PHYS) begin
          if (LIC_KIND <= vqe_pkg::LK_LIN_EVENT) begin
            word[11:0] = LIC_OFFSET;
          end
          word[15:12] = at;
          vec = (at == vqe_pkg::AT_LIN_EVT) || (at == vqe_pkg::AT_GP_EVT);
        end
      end
      vqe_pkg::RSN_SLT_VIOL: begin
        word[vqe_pkg::SLT_RD_BIT]    = SLT_READ;
        word[vqe_pkg::SLT_WR_BIT]    = SLT_WRITE;
        word[vqe_pkg::SLT_FETCH_BIT] = SLT_FETCH;
      end
      default: word = 64'h0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////

  always_comb begin
    s_nxt = s_r;
    if (take) begin
      s_nxt.detail = word;
      s_nxt.vec    = vec;
      s_nxt.reason = EXIT_REASON;
    end
    if (apb_wr && (PADDR == vqe_pkg::ADDR_CONTROL)) begin
      s_nxt.enable = PWDATA[vqe_pkg::CTRL_ENABLE_BIT];
      if (PWDATA[vqe_pkg::CTRL_CLEAR_BIT]) begin
        s_nxt.valid = 1'b0;
      end
    end
    // A new exit in the same cycle as a clear keeps the flag set.
    if (take) begin
      s_nxt.valid = 1'b1;
    end
    // Read data and error are prepared in the setup phase so the access phase has flop outputs.
    if (apb_setup) begin
      s_nxt.pslverr = !addr_known(PADDR);
      case (PADDR)
        vqe_pkg::ADDR_DETAIL_LO: s_nxt.prdata = s_r.detail[31:0];
        vqe_pkg::ADDR_DETAIL_HI: s_nxt.prdata = s_r.detail[63:32];
        vqe_pkg::ADDR_STATUS: begin
          s_nxt.prdata = 32'h0;
          s_nxt.prdata[vqe_pkg::STAT_VALID_BIT] = s_r.valid;
          s_nxt.prdata[vqe_pkg::STAT_REASON_LSB +: 3] = s_r.reason;
          s_nxt.prdata[vqe_pkg::STAT_VECTOR_BIT] = s_r.vec;
        end
        vqe_pkg::ADDR_CONTROL: begin
          s_nxt.prdata = 32'h0;
          s_nxt.prdata[vqe_pkg::CTRL_ENABLE_BIT] = s_r.enable;
        end
        default: s_nxt.prdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '{detail: vqe_pkg::DETAIL_RESET, vec: 1'b0, valid: 1'b0, reason: 3'h0,
               enable: vqe_pkg::ENABLE_RESET, prdata: 32'h0, pslverr: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign PRDATA          = s_r.prdata;
  assign PSLVERR         = s_r.pslverr && PSEL && PENABLE;
  assign PREADY          = 1'b1;
  assign EXIT_DETAIL     = s_r.detail;
  assign EVENT_VEC_VALID = s_r.vec;
  assign DETAIL_VALID    = s_r.valid;

  ////////////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!rst_n);

  sequence s_cap(logic [2:0] r);
    take && (EXIT_REASON == r);
  endsequence

  sequence s_lic_live;
    s_cap(vqe_pkg::RSN_LIC_PAGE) ##0 (LIC_KIND != vqe_pkg::LK_PHYS);
  endsequence

  a_dr_index_dir: assert property (s_cap(vqe_pkg::RSN_DR_MOVE) |=> (EXIT_DETAIL[2:0] == $past(DR_INDEX))
    && (EXIT_DETAIL[4] == $past(DR_READ_OUT))) else $error("debug move index or direction wrong");
  a_dr_direction: assert property (s_cap(vqe_pkg::RSN_DR_MOVE) ##0 DR_READ_OUT |=> EXIT_DETAIL[4])
    else $error("debug move read-out not flagged");
  a_dr_gpr_field: assert property (s_cap(vqe_pkg::RSN_DR_MOVE) |=> EXIT_DETAIL[11:8] == $past(GPR_INDEX))
    else $error("debug move operand register wrong");
  a_dr_zero_bits: assert property (s_cap(vqe_pkg::RSN_DR_MOVE) |=> EXIT_DETAIL[63:12] == 52'h0
    && EXIT_DETAIL[7:5] == 3'h0 && !EXIT_DETAIL[3]) else $error("debug move reserved bits set");
  a_io_size_code: assert property (s_cap(vqe_pkg::RSN_PORT_IO) |=> EXIT_DETAIL[2:0] ==
    (($past(IO_SIZE) == 2'h0) ? 3'h0 : ($past(IO_SIZE) == 2'h1) ? 3'h1 : 3'h3)) else $error("port size code wrong");
  a_io_flag_bits: assert property (s_cap(vqe_pkg::RSN_PORT_IO) |=> EXIT_DETAIL[6:3] ==
    {$past(IO_IMMEDIATE), $past(IO_REPEAT), $past(IO_STRING), $past(IO_INPUT)}) else $error("port flags wrong");
  a_io_port_zero: assert property (s_cap(vqe_pkg::RSN_PORT_IO) |=> EXIT_DETAIL[31:16] == $past(IO_PORT)
    && EXIT_DETAIL[63:32] == 32'h0 && EXIT_DETAIL[15:7] == 9'h0) else $error("port number or zeros wrong");
  a_monitor_wait_instruction_word: assert property (s_cap(vqe_pkg::RSN_MON_WAIT) |=> EXIT_DETAIL == {63'h0, $past(MON_ARMED)})
    else $error("monitor-wait word wrong");
  a_lic_vec_flag: assert property (s_lic_live |=> EVENT_VEC_VALID ==
    (EXIT_DETAIL[15:12] == vqe_pkg::AT_LIN_EVT || EXIT_DETAIL[15:12] == vqe_pkg::AT_GP_EVT))
    else $error("vectoring flag disagrees with access type");
  a_lic_type_set: assert property (s_lic_live |=> EXIT_DETAIL[15:12] inside {4'h0, 4'h1, 4'h2, 4'h3, 4'ha, 4'hf}
    && EXIT_DETAIL[63:16] == 48'h0) else $error("page access type illegal");
  a_lic_flush_rd: assert property (s_cap(vqe_pkg::RSN_LIC_PAGE) ##0 (LIC_KIND == vqe_pkg::LK_LIN_DATA)
    ##0 (LIC_INSTR == vqe_pkg::IC_CACHE_FLUSH) |=> EXIT_DETAIL[15:12] == vqe_pkg::AT_DATA_RD)
    else $error("flush access not a data read");
  a_lic_phys_zero: assert property (s_cap(vqe_pkg::RSN_LIC_PAGE) ##0 (LIC_KIND == vqe_pkg::LK_PHYS)
    |=> EXIT_DETAIL == 64'h0 && !EVENT_VEC_VALID) else $error("physical page access word not zero");
  a_slt_bits: assert property (s_cap(vqe_pkg::RSN_SLT_VIOL) |=> EXIT_DETAIL ==
    {61'h0, $past(SLT_FETCH), $past(SLT_WRITE), $past(SLT_READ)}) else $error("violation bits wrong");
  a_valid_hold: assert property (take ##1 (!take && !clr_req) [*2] |-> DETAIL_VALID)
    else $error("captured exit lost its valid flag");

  // Set wins over clear: a capture always leaves the flag up.
  a_valid_set_wins: assert property (take |=> DETAIL_VALID)
    else $error("capture did not set valid");

  a_clear_drops: assert property (clr_req && !take |=> !DETAIL_VALID)
    else $error("clear did not drop valid");

  a_idle_keeps_word: assert property (!take |=> $stable(EXIT_DETAIL) && $stable(EVENT_VEC_VALID))
    else $error("stored word changed without a capture");

  a_disabled_ignored: assert property (EXIT_VALID && !s_r.enable && !clr_req |=> $stable(DETAIL_VALID))
    else $error("exit taken while capture disabled");

  a_other_zero: assert property (take && (EXIT_REASON > 3'h5 || EXIT_REASON == 3'h0) |=> EXIT_DETAIL == 64'h0)
    else $error("unknown reason gave a non-zero word");

  a_vec_non_page: assert property (take && EXIT_REASON != vqe_pkg::RSN_LIC_PAGE |=> !EVENT_VEC_VALID)
    else $error("vectoring flag set outside a page access");

  a_dr_write_in: assert property (s_cap(vqe_pkg::RSN_DR_MOVE) ##0 !DR_READ_OUT |=> !EXIT_DETAIL[4])
    else $error("debug move write-in flagged as read-out");

  a_io_size_legal: assert property (s_cap(vqe_pkg::RSN_PORT_IO) |=> EXIT_DETAIL[2:0] != 3'h2
    && !EXIT_DETAIL[2]) else $error("port size code outside the legal set");

  a_lic_offset: assert property (s_cap(vqe_pkg::RSN_LIC_PAGE) ##0 (LIC_KIND <= vqe_pkg::LK_LIN_EVENT)
    |=> EXIT_DETAIL[11:0] == $past(LIC_OFFSET)) else $error("page offset wrong");

  // Guest-physical offsets are undefined and therefore driven to zero.
  a_lic_gp_zero: assert property (s_cap(vqe_pkg::RSN_LIC_PAGE) ##0 (LIC_KIND == vqe_pkg::LK_GP_EVENT)
    |=> EXIT_DETAIL[11:0] == 12'h0) else $error("guest-physical offset not zero");

  a_lic_fetch_type: assert property (s_cap(vqe_pkg::RSN_LIC_PAGE) ##0 (LIC_KIND == vqe_pkg::LK_LIN_FETCH)
    |=> EXIT_DETAIL[15:12] == vqe_pkg::AT_FETCH) else $error("fetch access type wrong");

  a_lic_store_wr: assert property (s_cap(vqe_pkg::RSN_LIC_PAGE) ##0 (LIC_KIND == vqe_pkg::LK_LIN_DATA)
    ##0 (LIC_INSTR inside {vqe_pkg::IC_STACK_ENTER, vqe_pkg::IC_MASKED_STORE_A, vqe_pkg::IC_MASKED_STORE_B})
    |=> EXIT_DETAIL[15:12] == vqe_pkg::AT_DATA_WR) else $error("store access not a data write");

  a_lic_monitor_rd: assert property (s_cap(vqe_pkg::RSN_LIC_PAGE) ##0 (LIC_KIND == vqe_pkg::LK_LIN_DATA)
    ##0 (LIC_INSTR == vqe_pkg::IC_MONITOR_SETUP) |=> EXIT_DETAIL[15:12] == vqe_pkg::AT_DATA_RD)
    else $error("monitor-setup access not a data read");

  a_lic_pf_follow: assert property (s_cap(vqe_pkg::RSN_LIC_PAGE) ##0 (LIC_KIND == vqe_pkg::LK_LIN_DATA)
    ##0 (LIC_INSTR == vqe_pkg::IC_OTHER) |=> EXIT_DETAIL[15:12] == {3'h0, $past(LIC_PF_WRITE)})
    else $error("data access ignores the fault write sense");

  ////////////////////////////////////////////////////////////////////////////////

  // The slave never stretches a transfer, so a master waiting on ready never hangs.
  a_apb_ready: assert property (PSEL && PENABLE |-> PREADY)
    else $error("ready low in access phase");

  a_apb_err_map: assert property (PSEL && PENABLE && !addr_known(PADDR) |-> PSLVERR)
    else $error("unmapped access without error");

  a_apb_no_err: assert property (PSEL && PENABLE && addr_known(PADDR) |-> !PSLVERR)
    else $error("mapped access flagged as error");

  a_apb_rd_lo: assert property (apb_setup && PADDR == vqe_pkg::ADDR_DETAIL_LO
    |=> PRDATA == $past(EXIT_DETAIL[31:0])) else $error("low word read wrong");

  a_apb_rd_hi: assert property (apb_setup && PADDR == vqe_pkg::ADDR_DETAIL_HI
    |=> PRDATA == $past(EXIT_DETAIL[63:32])) else $error("high word read wrong");

  a_apb_rd_stat: assert property (apb_setup && PADDR == vqe_pkg::ADDR_STATUS
    |=> PRDATA[vqe_pkg::STAT_VALID_BIT] == $past(DETAIL_VALID)
    && PRDATA[vqe_pkg::STAT_VECTOR_BIT] == $past(EVENT_VEC_VALID)) else $error("status read wrong");

  // The clear bit is a strobe and must read back as zero.
  a_apb_rd_ctrl: assert property (apb_setup && PADDR == vqe_pkg::ADDR_CONTROL |=> PRDATA[31:1] == 31'h0)
    else $error("control read shows stray bits");

  a_enable_write: assert property (apb_wr && PADDR == vqe_pkg::ADDR_CONTROL
    |=> s_r.enable == $past(PWDATA[vqe_pkg::CTRL_ENABLE_BIT])) else $error("enable write lost");

endmodule

// ===== core/vqe_pkg.sv
// Package with the offsets, field positions, encodings and reset values of the exit-detail encoder.
package vqe_pkg;

  // Exit reasons presented by the core.
  typedef enum logic [2:0] {
    RSN_NONE     = 3'b000,
    RSN_DR_MOVE  = 3'b001,
    RSN_PORT_IO  = 3'b010,
    RSN_MON_WAIT = 3'b011,
    RSN_LIC_PAGE = 3'b100,
    RSN_SLT_VIOL = 3'b101
  } vqe_reason_t;

  // Kind of access to the interrupt-controller page.
  typedef enum logic [2:0] {
    LK_LIN_DATA  = 3'b000,
    LK_LIN_FETCH = 3'b001,
    LK_LIN_EVENT = 3'b010,
    LK_GP_EVENT  = 3'b011,
    LK_GP_EXEC   = 3'b100,
    LK_PHYS      = 3'b101
  } vqe_lic_kind_t;

  // Instruction class behind a data access to the interrupt-controller page.
  typedef enum logic [2:0] {
    IC_OTHER          = 3'b000,
    IC_CACHE_FLUSH    = 3'b001,
    IC_MONITOR_SETUP  = 3'b010,
    IC_STACK_ENTER    = 3'b011,
    IC_MASKED_STORE_A = 3'b100,
    IC_MASKED_STORE_B = 3'b101
  } vqe_instr_t;

  // Register byte addresses on the APB.
  localparam logic [7:0] ADDR_DETAIL_LO = 8'h00;
  localparam logic [7:0] ADDR_DETAIL_HI = 8'h04;
  localparam logic [7:0] ADDR_STATUS    = 8'h08;
  localparam logic [7:0] ADDR_CONTROL   = 8'h0c;

  // Control and status fields.
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_CLEAR_BIT  = 1;
  localparam int STAT_VALID_BIT  = 0;
  localparam int STAT_REASON_LSB = 4;
  localparam int STAT_VECTOR_BIT = 8;

  // Field positions inside the exit-detail word.
  localparam int DR_DIR_BIT   = 4;
  localparam int IO_IN_BIT    = 3;
  localparam int IO_STR_BIT   = 4;
  localparam int IO_REP_BIT   = 5;
  localparam int IO_IMM_BIT   = 6;
  localparam int SLT_RD_BIT   = 0;
  localparam int SLT_WR_BIT   = 1;
  localparam int SLT_FETCH_BIT = 2;

  // Port access size codes.
  localparam logic [2:0] IO_SZ_1 = 3'h0;
  localparam logic [2:0] IO_SZ_2 = 3'h1;
  localparam logic [2:0] IO_SZ_4 = 3'h3;

  // Interrupt-controller page access types.
  localparam logic [3:0] AT_DATA_RD  = 4'h0;
  localparam logic [3:0] AT_DATA_WR  = 4'h1;
  localparam logic [3:0] AT_FETCH    = 4'h2;
  localparam logic [3:0] AT_LIN_EVT  = 4'h3;
  localparam logic [3:0] AT_GP_EVT   = 4'ha;
  localparam logic [3:0] AT_GP_EXEC  = 4'hf;

  // Values after reset.
  localparam logic [63:0] DETAIL_RESET = 64'h0;
  localparam logic        ENABLE_RESET = 1'b1;

endpackage

// ===== dv/vqe_exit_encoder_tb.sv
// Self-checking bench for the exit-detail encoder: random exits, register reads and control over APB.
`timescale 1ns/100ps

module vqe_exit_encoder_tb;
  logic        CORE_CLK, RESET_N, PSEL, PENABLE, PWRITE, EXIT_VALID, DR_READ_OUT, IO_INPUT, IO_STRING;
  logic        IO_REPEAT, IO_IMMEDIATE, MON_ARMED, LIC_PF_WRITE, SLT_READ, SLT_WRITE, SLT_FETCH;
  logic        PREADY, PSLVERR, EVENT_VEC_VALID, DETAIL_VALID, cap_en, pend, er;
  logic [1:0]  IO_SIZE;
  logic [2:0]  EXIT_REASON, DR_INDEX, LIC_KIND, LIC_INSTR, last_rsn;
  logic [3:0]  GPR_INDEX;
  logic [7:0]  PADDR;
  logic [11:0] LIC_OFFSET;
  logic [15:0] IO_PORT;
  logic [31:0] PWDATA, PRDATA, lf, a, b, rd;
  logic [63:0] EXIT_DETAIL;
  logic [64:0] last, note;
  logic [64:0] exp_q[$];
  int          error_cnt, checks_done;

  vqe_exit_encoder dut (.CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .EXIT_VALID(EXIT_VALID),
    .EXIT_REASON(EXIT_REASON), .DR_INDEX(DR_INDEX), .DR_READ_OUT(DR_READ_OUT), .GPR_INDEX(GPR_INDEX),
    .IO_SIZE(IO_SIZE), .IO_INPUT(IO_INPUT), .IO_STRING(IO_STRING), .IO_REPEAT(IO_REPEAT),
    .IO_IMMEDIATE(IO_IMMEDIATE), .IO_PORT(IO_PORT), .MON_ARMED(MON_ARMED), .LIC_KIND(LIC_KIND),
    .LIC_INSTR(LIC_INSTR), .LIC_PF_WRITE(LIC_PF_WRITE), .LIC_OFFSET(LIC_OFFSET), .SLT_READ(SLT_READ),
    .SLT_WRITE(SLT_WRITE), .SLT_FETCH(SLT_FETCH), .EXIT_DETAIL(EXIT_DETAIL), .EVENT_VEC_VALID(EVENT_VEC_VALID),
    .DETAIL_VALID(DETAIL_VALID));

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    CORE_CLK = 1'b0;
    forever #20 CORE_CLK = ~CORE_CLK;
  end

  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic bit miss(input bit bad);
    checks_done++;
    if (bad) error_cnt++;
    return bad;
  endfunction

  // Expected word in bits 63:0 and the vectoring flag in bit 64, from the same fields that exit_go drives.
  function automatic logic [64:0] model(input logic [2:0] r, input logic [31:0] x, input logic [31:0] y);
    logic [63:0] w;
    logic [3:0]  at;
    logic        v;
    w = 64'h0;
    v = 1'b0;
    case (r)
      3'd1: w = {52'h0, x[7:4], 3'h0, x[3], 1'b0, x[2:0]};
      3'd2: w = {32'h0, y[15:0], 9'h0, x[13:10], (x[9:8] == 2'd0) ? 3'h0 : (x[9:8] == 2'd1) ? 3'h1 : 3'h3};
      3'd3: w = {63'h0, x[14]};
      3'd4: begin
        case (x[17:15])
          3'd0: at = (x[20:18] inside {3'd1, 3'd2}) ? 4'h0 : (x[20:18] inside {3'd3, 3'd4, 3'd5}) ? 4'h1 : {3'h0, x[21]};
          3'd1: at = 4'h2;
          3'd2: at = 4'h3;
          3'd3: at = 4'ha;
          default: at = 4'hf;
        endcase
        if (x[17:15] != 3'd5) w = {48'h0, at, (x[17:15] < 3'd3) ? y[27:16] : 12'h0};
        v = (x[17:15] == 3'd2) || (x[17:15] == 3'd3);
      end
      3'd5: w = {61'h0, x[24:22]};
      default: w = 64'h0;
    endcase
    return {v, w};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
    logic rdy;
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= ad;
    PWDATA <= wd;
    @(posedge CORE_CLK);
    PENABLE <= 1'b1;
    rdy = 1'b0;
    while (rdy !== 1'b1) begin
      @(posedge CORE_CLK);
      rd = PRDATA;
      er = PSLVERR;
      rdy = PREADY;
    end
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CORE_CLK);
  endtask

  task automatic rdchk(input logic [7:0] ad, input logic [31:0] ex, input logic ee);
    apb(1'b0, ad, 32'h0);
    if (miss(rd !== ex || er !== ee)) $display("BAD %0t read %h gave %h err %b", $time, ad, rd, er);
  endtask

  task automatic exit_go(input logic [2:0] r, input logic [31:0] x, input logic [31:0] y);
    EXIT_VALID <= 1'b1;
    EXIT_REASON <= r;
    {SLT_FETCH, SLT_WRITE, SLT_READ, LIC_PF_WRITE, LIC_INSTR, LIC_KIND, MON_ARMED} <= x[24:14];
    {IO_IMMEDIATE, IO_REPEAT, IO_STRING, IO_INPUT, IO_SIZE, GPR_INDEX, DR_READ_OUT, DR_INDEX} <= x[13:0];
    IO_PORT <= y[15:0];
    LIC_OFFSET <= y[27:16];
    if (cap_en) begin
      last = model(r, x, y);
      last_rsn = r;
      exp_q.push_back(last);
    end
    @(posedge CORE_CLK);
  endtask

  task automatic idle();
    EXIT_VALID <= 1'b0;
    repeat (2) @(posedge CORE_CLK);
  endtask

  task automatic close_out();
    if (error_cnt == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // The capture edge is noted here and judged half a cycle later, once the registered outputs have settled.
  always @(posedge CORE_CLK) pend <= EXIT_VALID & cap_en & RESET_N;

  always @(negedge CORE_CLK) begin
    if (pend) begin
      note = (exp_q.size() > 0) ? exp_q.pop_front() : 65'bx;
      if (miss({EVENT_VEC_VALID, EXIT_DETAIL} !== note || DETAIL_VALID !== 1'b1)) $display("BAD %0t word %h", $time, EXIT_DETAIL);
    end
  end

  initial begin
    #800000;
    error_cnt++;
    close_out();
  end

  initial begin
    {PSEL, PENABLE, PWRITE, PADDR, PWDATA, EXIT_VALID, EXIT_REASON} = '0;
    {DR_INDEX, DR_READ_OUT, GPR_INDEX, IO_SIZE, IO_INPUT, IO_STRING, IO_REPEAT, IO_IMMEDIATE, IO_PORT} = '0;
    {MON_ARMED, LIC_KIND, LIC_INSTR, LIC_PF_WRITE, LIC_OFFSET, SLT_READ, SLT_WRITE, SLT_FETCH} = '0;
    {RESET_N, pend, error_cnt, checks_done} = '0;
    cap_en = 1'b1;
    lf = 32'h1b854549;
    repeat (5) @(posedge CORE_CLK);
    RESET_N <= 1'b1;
    repeat (3) @(posedge CORE_CLK);
    rdchk(vqe_pkg::ADDR_CONTROL, 32'h1, 1'b0);
    rdchk(vqe_pkg::ADDR_STATUS, 32'h0, 1'b0);
    // Back-to-back exits walk every reason code; page-access kind and instruction class come from random fields.
    for (int i = 0; i < 400; i++) begin
      lf = nxt(lf);
      a = lf;
      lf = nxt(lf);
      b = lf;
      exit_go(i[2:0], a, b);
    end
    exit_go(3'd4, 32'h00010000, 32'h0abc0000);
    idle();
    rdchk(vqe_pkg::ADDR_DETAIL_LO, last[31:0], 1'b0);
    rdchk(vqe_pkg::ADDR_DETAIL_HI, last[63:32], 1'b0);
    rdchk(vqe_pkg::ADDR_STATUS, 32'h00000141, 1'b0);
    apb(1'b1, vqe_pkg::ADDR_DETAIL_LO, 32'hffffffff);
    rdchk(vqe_pkg::ADDR_DETAIL_LO, last[31:0], 1'b0);
    rdchk(8'h10, 32'h0, 1'b1);
    apb(1'b1, 8'h10, 32'h0);
    if (miss(er !== 1'b1)) $display("BAD %0t unmapped write accepted", $time);
    apb(1'b1, vqe_pkg::ADDR_CONTROL, 32'h3);
    if (miss(DETAIL_VALID !== 1'b0)) $display("BAD %0t valid not cleared", $time);
    // Capture disabled: the exit must leave no trace, so the stored word stays that of the last taken exit.
    apb(1'b1, vqe_pkg::ADDR_CONTROL, 32'h0);
    cap_en = 1'b0;
    exit_go(3'd2, 32'h0000ffff, 32'h0000ffff);
    idle();
    if (miss(EXIT_DETAIL !== last[63:0] || DETAIL_VALID !== 1'b0)) $display("BAD %0t disabled exit taken", $time);
    rdchk(vqe_pkg::ADDR_CONTROL, 32'h0, 1'b0);
    apb(1'b1, vqe_pkg::ADDR_CONTROL, 32'h1);
    cap_en = 1'b1;
    exit_go(3'd3, 32'h00004000, 32'h0);
    idle();
    rdchk(vqe_pkg::ADDR_STATUS, 32'h00000031, 1'b0);
    RESET_N <= 1'b0;
    repeat (2) @(posedge CORE_CLK);
    @(negedge CORE_CLK);
    if (miss({EVENT_VEC_VALID, DETAIL_VALID, EXIT_DETAIL} !== 66'h0)) $display("BAD %0t outputs kept in reset", $time);
    @(posedge CORE_CLK);
    RESET_N <= 1'b1;
    repeat (3) @(posedge CORE_CLK);
    rdchk(vqe_pkg::ADDR_CONTROL, 32'h1, 1'b0);
    close_out();
  end
endmodule
